// File: sim/rfp_prog_model.sv
/*
 * rfp_prog_model: serial programmer on the far side of the core's
 * programming pins; shifts 14-bit words lsb first.
 * Assumes the core samples data on a sampled rising programming clock.
 */
`timescale 1ns/1ps
module rfp_prog_model (
   input wire logic ref_clk_i,
   output logic prog_clk_o,
   output logic prog_data_o
);
   // clock stands low between words, data line starts high
   initial begin
      prog_clk_o = 1'b0;
      prog_data_o = 1'b1;
   end

   // one whole word, clock high two reference cycles and low three
   task automatic send_word(input logic [13:0] word);
      for (int i = 0; i < 14; i++) begin
         @(negedge ref_clk_i);
         prog_data_o = word[i];
         repeat (2) @(negedge ref_clk_i);
         prog_clk_o = 1'b1;
         repeat (2) @(negedge ref_clk_i);
         prog_clk_o = 1'b0;
         prog_data_o = ~word[i]; // hold over: line no longer valid
      end
      repeat (4) @(negedge ref_clk_i);
   endtask : send_word
endmodule : rfp_prog_model

// File: sim/tb_rfp_core.sv
/*
 * tb_rfp_core: self-checking bench of the fetch/execute core.
 * Assumes the programmer model loads the program store before run.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      n_checks++; \
      if ((got) !== (ex)) begin \
         errors++; \
         $display("Error %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb_rfp_core;
   logic clk, resetn, rc_mode, irq_en, prog_mode, tsel, a4, a4_low, b0;
   logic [3:0] chg;
   logic b6, b7, nv_we, a4_out, a4_oe, tick, irq_taken;
   logic [5:0] nv_addr;
   logic [7:0] nv_wdata, nv_rdata, w;
   logic [12:0] pc;
   logic [13:0] ir;
   logic [2:0] st;
   logic [1:0] ph;
   logic qclk;
   int errors = 0;
   int n_checks = 0;
   // program image and expected state per execute cycle
   localparam logic [13:0] PROG [12] = '{14'h0a55, 14'h0bab, 14'h0c01,
      14'h0c00, 14'h018c, 14'h0a00, 14'h040c, 14'h2009, 14'h0a77,
      14'h0a3c, 14'h0000, 14'h240a};
   localparam logic [13:0] E_IR [15] = '{14'h0000, 14'h0a55, 14'h0bab,
      14'h0c01, 14'h0c00, 14'h018c, 14'h0a00, 14'h040c, 14'h2009,
      14'h0000, 14'h0a3c, 14'h0000, 14'h240a, 14'h0000, 14'h0000};
   localparam logic [12:0] E_PC [15] = '{13'h0001, 13'h0002, 13'h0003,
      13'h0004, 13'h0005, 13'h0006, 13'h0007, 13'h0008, 13'h0009,
      13'h000a, 13'h000b, 13'h000c, 13'h000d, 13'h040b, 13'h040c};
   localparam logic [7:0] E_W [15] = '{8'h00, 8'h55, 8'h00, 8'h01,
      8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h3c, 8'h3c, 8'h3c,
      8'h3c, 8'h3c};
   localparam logic [2:0] E_ST [15] = '{3'h0, 3'h0, 3'h7, 3'h3, 3'h0,
      3'h0, 3'h0, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3};

   rfp_core dut (.ref_clk_i(clk), .resetn_i(resetn), .rc_mode_i(rc_mode),
      .irq_enable_i(irq_en), .prog_mode_i(prog_mode),
      .timer_clk_sel_i(tsel), .porta_bit4_timer_clock_in_i(a4),
      .porta4_drive_low_i(a4_low), .portb_bit0_ext_irq_i(b0),
      .portb_change_irq_i(chg), .portb_bit6_prog_clock_i(b6),
      .portb_bit7_prog_data_i(b7), .nv_addr_i(nv_addr),
      .nv_wdata_i(nv_wdata), .nv_we_i(nv_we), .nv_rdata_o(nv_rdata),
      .quarter_rate_clock_output_o(qclk), .porta4_out_o(a4_out),
      .porta4_oe_o(a4_oe), .timer_tick_o(tick), .irq_taken_o(irq_taken),
      .instruction_pointer_o(pc), .instr_reg_o(ir), .accumulator_o(w),
      .status_o(st), .phase_o(ph));
   rfp_prog_model prog (.ref_clk_i(clk), .prog_clk_o(b6),
      .prog_data_o(b7));

   // 100 MHz reference clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test

   task automatic wait_phase(input logic [1:0] p);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ph !== p && n < 20);
      if (ph !== p) begin
         errors++;
         finish_test();
      end
   endtask : wait_phase

   task automatic wait_irq(input string nm);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq_taken !== 1'b1 && n < 400);
      if (irq_taken !== 1'b1) begin
         errors++;
         finish_test();
      end
      `CHK(nm, rfp_pkg::IRQ_VEC, pc)
   endtask : wait_irq

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic run_pipeline;
      for (int i = 0; i < 15; i++) begin
         wait_phase(2'd1);
         `CHK("instr_reg", E_IR[i], ir)
         `CHK("pointer", E_PC[i], pc)
         wait_phase(2'd0);
         `CHK("accumulator", E_W[i], w)
         `CHK("status", E_ST[i], st)
      end
   endtask : run_pipeline

   task automatic check_phases;
      logic [1:0] prev;
      @(negedge clk);
      prev = ph;
      repeat (8) begin
         @(negedge clk);
         `CHK("phase", prev + 2'd1, ph)
         `CHK("quarter clock", ph[1], qclk)
         prev = ph;
      end
   endtask : check_phases

   task automatic check_irq;
      logic seen;
      seen = 1'b0;
      b0 = 1'b1;
      repeat (48) begin
         @(negedge clk);
         if (irq_taken === 1'b1)
            seen = 1'b1;
      end
      `CHK("masked irq", 1'b0, seen)
      irq_en = 1'b1;
      wait_irq("ext irq");
      repeat (8) @(negedge clk);
      chg = 4'h4;
      wait_irq("change irq");
   endtask : check_irq

   task automatic check_pins;
      int ticks;
      ticks = 0;
      a4_low = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("a4 enable", 1'b1, a4_oe)
      `CHK("a4 level", 1'b0, a4_out)
      tsel = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("a4 enable", 1'b0, a4_oe)
      a4 = 1'b1;
      repeat (6) begin
         @(negedge clk);
         if (tick === 1'b1)
            ticks++;
      end
      `CHK("timer ticks", 1, ticks)
   endtask : check_pins

   task automatic check_nv;
      nv_we = 1'b1;
      nv_addr = 6'h3f;
      nv_wdata = 8'ha5;
      @(negedge clk);
      nv_addr = 6'h00;
      nv_wdata = 8'h5a;
      @(negedge clk);
      nv_we = 1'b0;
      nv_addr = 6'h3f;
      @(negedge clk);
      `CHK("nv read", 8'ha5, nv_rdata)
      nv_addr = 6'h00;
      @(negedge clk);
      `CHK("nv read", 8'h5a, nv_rdata)
   endtask : check_nv

   // main sequence
   initial begin
      {resetn, irq_en, tsel, a4, a4_low, b0, nv_we} = '0;
      {rc_mode, prog_mode} = 2'b11;
      chg = 4'h0;
      nv_addr = 6'h00;
      nv_wdata = 8'h00;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      foreach (PROG[i])
         prog.send_word(PROG[i]);
      prog_mode = 1'b0;
      resetn = 1'b0;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      run_pipeline();
      check_phases();
      check_irq();
      check_pins();
      check_nv();
      finish_test();
   end
endmodule : tb_rfp_core

// File: src/rfp_core.sv
/*
 * rfp_core: four-phase fetch/execute pipeline of the 8-bit core, with
 * on-chip program store, data registers, nonvolatile data store and the
 * pin duties that belong to the core.
 * Assumes all pin inputs are synchronous to ref_clk_i and that rc_mode_i
 * and the select inputs are static configuration.
 */
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Overview of operation
// RQ1 - fetch whole 14-bit words on program bus
// RQ2 - overlap fetch with execute, one cycle each
// RQ3 - 1K word program store, all on-chip
// RQ4 - 36 data bytes plus 64-byte nonvolatile store
// RQ5 - 8-bit unit: add, subtract, shift, logic
// RQ6 - operands: accumulator with file or literal
// RQ7 - accumulator has no data memory address
// RQ8 - update carry, digit carry and zero flags
// RQ9 - subtraction carries mean no borrow
// RQ10 - four phases form one instruction cycle
// RQ11 - pointer increments phase one, fetch phase four
// RQ12 - instruction held, executed phases two to four
// RQ13 - operand read phase two, write phase four
// RQ14 - jumps take two instruction cycles
// RQ15 - quarter rate clock out in RC mode
// RQ16 - low master clear resets the device
// RQ17 - port A bit 4: timer clock, open drain
// RQ18 - port B bit 0 external interrupt
// RQ19 - port B bits 4-7 change interrupt
// RQ20 - port B bits 6/7 serial programming
// RQ21 - branch discards prefetched instruction
// RQ22 - reset vector zero, interrupt vector four
// RQ23 - 13-bit pointer wraps onto 1K words
// ---------------------------------------------------------------------
module rfp_core (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic rc_mode_i,
   input wire logic irq_enable_i,
   input wire logic prog_mode_i,
   input wire logic timer_clk_sel_i,
   input wire logic porta_bit4_timer_clock_in_i,
   input wire logic porta4_drive_low_i,
   input wire logic portb_bit0_ext_irq_i,
   input wire logic [3:0] portb_change_irq_i,
   input wire logic portb_bit6_prog_clock_i,
   input wire logic portb_bit7_prog_data_i,
   input wire logic [5:0] nv_addr_i,
   input wire logic [7:0] nv_wdata_i,
   input wire logic nv_we_i,
   output logic [7:0] nv_rdata_o,
   output logic quarter_rate_clock_output_o,
   output logic porta4_out_o,
   output logic porta4_oe_o,
   output logic timer_tick_o,
   output logic irq_taken_o,
   output logic [12:0] instruction_pointer_o,
   output logic [13:0] instr_reg_o,
   output logic [7:0] accumulator_o,
   output logic [2:0] status_o,
   output logic [1:0] phase_o
);

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [13:0] prog_mem [rfp_pkg::PROG_WORDS];  // RQ3
   logic [7:0] gpr_mem [rfp_pkg::GPR_COUNT];     // RQ4
   logic [7:0] nv_mem [rfp_pkg::NV_WORDS];       // RQ4

   rfp_pkg::rfp_state_s st_r;
   rfp_pkg::rfp_state_s st_nxt;
   logic take_irq;
   logic is_jmp;

   // ------------------------------------------------------------------
   // functions
   // ------------------------------------------------------------------
   // gpr window test and index
   function automatic logic in_gpr(input logic [6:0] f);
      in_gpr = (f >= rfp_pkg::GPR_BASE) &&
               (f < rfp_pkg::GPR_BASE + 7'(rfp_pkg::GPR_COUNT));
   endfunction : in_gpr

   function automatic logic [5:0] gpr_idx(input logic [6:0] f);
      logic [6:0] d;
      d = f - rfp_pkg::GPR_BASE;
      gpr_idx = d[5:0];
   endfunction : gpr_idx

   function automatic logic is_jump(input logic [13:0] ins);
      is_jump = ins[rfp_pkg::JUMP_BIT];
   endfunction : is_jump

   function automatic logic [12:0] jump_target(input logic [13:0] ins);
      jump_target = {2'h0, ins[10:0]};
   endfunction : jump_target

   // arithmetic unit: operand a is file or literal, b is accumulator
   function automatic rfp_pkg::rfp_alu_s alu(input logic [13:0] ins,
                                             input logic [7:0] fval,
                                             input logic [7:0] wv,
                                             input logic [2:0] stat);
      rfp_pkg::rfp_alu_s r;
      logic [3:0] op;
      logic [7:0] a;
      logic [8:0] sum;
      logic [4:0] nib;
      logic lit;
      op = ins[11:8];
      lit = (op >= rfp_pkg::OP_MOVLW);
      a = lit ? ins[7:0] : fval;                          // RQ6
      sum = 9'h000;
      nib = 5'h00;
      r = '0;
      r.flags = stat;
      r.to_w = lit ? 1'b1 : !ins[7];
      r.to_file = !lit && ins[7];
      case (op)
         rfp_pkg::OP_NOP: begin
            r.to_w = 1'b0;
         end
         rfp_pkg::OP_MOVWF: begin
            r.res = wv;
            r.to_w = 1'b0;
            r.to_file = 1'b1;
         end
         rfp_pkg::OP_MOVF, rfp_pkg::OP_MOVLW: begin
            r.res = a;
            r.upd = lit ? 3'h0 : 3'h4;
         end
         rfp_pkg::OP_ADDWF, rfp_pkg::OP_ADDLW: begin
            sum = {1'b0, a} + {1'b0, wv};                   // RQ5
            nib = {1'b0, a[3:0]} + {1'b0, wv[3:0]};
            r.res = sum[7:0];
            r.flags[rfp_pkg::C_BIT] = sum[8];
            r.flags[rfp_pkg::DC_BIT] = nib[4];
            r.upd = 3'h7;
         end
         rfp_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE, rfp_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL: begin
            // two's complement a - w; carry out set means no borrow
            sum = {1'b0, a} + {1'b0, ~wv} + 9'h001;         // RQ9
            nib = {1'b0, a[3:0]} + {1'b0, ~wv[3:0]} + 5'h01;
            r.res = sum[7:0];
            r.flags[rfp_pkg::C_BIT] = sum[8];
            r.flags[rfp_pkg::DC_BIT] = nib[4];
            r.upd = 3'h7;
         end
         rfp_pkg::OP_ANDWF, rfp_pkg::OP_ANDLW: begin
            r.res = a & wv;
            r.upd = 3'h4;
         end
         rfp_pkg::OP_IORWF: begin
            r.res = a | wv;
            r.upd = 3'h4;
         end
         rfp_pkg::OP_XORWF: begin
            r.res = a ^ wv;
            r.upd = 3'h4;
         end
         rfp_pkg::OP_RRF: begin
            r.res = {stat[rfp_pkg::C_BIT], a[7:1]};
            r.flags[rfp_pkg::C_BIT] = a[0];
            r.upd = 3'h1;
         end
         rfp_pkg::OP_RLF: begin
            r.res = {a[6:0], stat[rfp_pkg::C_BIT]};
            r.flags[rfp_pkg::C_BIT] = a[7];
            r.upd = 3'h1;
         end
         default: begin
            r.to_w = 1'b0;
            r.to_file = 1'b0;
         end
      endcase
      if (r.upd[2]) begin
         r.flags[rfp_pkg::Z_BIT] = (r.res == 8'h00);       // RQ8
      end
      if (is_jump(ins)) begin
         r.to_w = 1'b0;
         r.to_file = 1'b0;
         r.upd = 3'h0;
      end
      alu = r;
   endfunction : alu

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // phase sequencer, pipeline, pin duties and programming shifter
   always_comb begin
      st_nxt = st_r;
      st_nxt.irq_taken = 1'b0;
      st_nxt.timer_tick = 1'b0;
      st_nxt.prog_we = 1'b0;
      is_jmp = is_jump(st_r.ir);
      take_irq = irq_enable_i && (st_r.ext_pend || st_r.chg_pend) &&
                 !is_jmp && !st_r.flush;
      // sticky interrupt requests; a new edge beats the clear
      if (st_r.ph == rfp_pkg::PH_FOUR && take_irq) begin
         st_nxt.ext_pend = 1'b0;
         st_nxt.chg_pend = 1'b0;
      end
      st_nxt.rb0_prev = portb_bit0_ext_irq_i;
      st_nxt.rb_hi_prev = portb_change_irq_i;
      if (portb_bit0_ext_irq_i && !st_r.rb0_prev) begin
         st_nxt.ext_pend = 1'b1;                            // RQ18
      end
      if (portb_change_irq_i != st_r.rb_hi_prev) begin
         st_nxt.chg_pend = 1'b1;                            // RQ19
      end
      // timer clock input and open-drain output on port A bit 4
      st_nxt.ra4_prev = porta_bit4_timer_clock_in_i;
      st_nxt.timer_tick = timer_clk_sel_i &&
                          porta_bit4_timer_clock_in_i && !st_r.ra4_prev;
      st_nxt.ra4_oe = !timer_clk_sel_i && porta4_drive_low_i;  // RQ17
      // quarter rate clock: low in phases one and two, high after
      st_nxt.clk_out = rc_mode_i && (st_r.ph == rfp_pkg::PH_TWO ||
                                     st_r.ph == rfp_pkg::PH_THREE); // RQ15
      st_nxt.nv_rdata = nv_mem[nv_addr_i];
      case (st_r.ph)
         rfp_pkg::PH_ONE: begin
            st_nxt.ph = rfp_pkg::PH_TWO;                    // RQ10
            st_nxt.fetch_addr = st_r.pc;
            st_nxt.pc = st_r.pc + 13'h0001;                 // RQ11
            st_nxt.ir = st_r.flush ? rfp_pkg::INSTR_NOP :
                        st_r.fetch_word;                    // RQ2 RQ12 RQ21
            st_nxt.flush = 1'b0;
         end
         rfp_pkg::PH_TWO: begin
            st_nxt.ph = rfp_pkg::PH_THREE;
            // operand read; the accumulator is never an address
            if (st_r.ir[6:0] == rfp_pkg::STATUS_ADDR) begin  // RQ7
               st_nxt.operand = {5'h00, st_r.status};
            end else if (in_gpr(st_r.ir[6:0])) begin
               st_nxt.operand = gpr_mem[gpr_idx(st_r.ir[6:0])];  // RQ13
            end else begin
               st_nxt.operand = 8'h00;
            end
         end
         rfp_pkg::PH_THREE: begin
            st_nxt.ph = rfp_pkg::PH_FOUR;
            st_nxt.alu = alu(st_r.ir, st_r.operand, st_r.w,
                             st_r.status);                  // RQ5
         end
         rfp_pkg::PH_FOUR: begin
            st_nxt.ph = rfp_pkg::PH_ONE;
            // whole word fetched; upper pointer bits alias
            st_nxt.fetch_word =
               prog_mem[st_r.fetch_addr[rfp_pkg::PROG_AW-1:0]]; // RQ1 RQ23
            for (int i = 0; i < 3; i++) begin
               if (st_r.alu.upd[i]) begin
                  st_nxt.status[i] = st_r.alu.flags[i];     // RQ8
               end
            end
            if (st_r.alu.to_w) begin
               st_nxt.w = st_r.alu.res;                     // RQ6
            end
            if (st_r.alu.to_file &&
                st_r.ir[6:0] == rfp_pkg::STATUS_ADDR) begin
               st_nxt.status = st_r.alu.res[2:0];
            end
            if (is_jmp) begin
               st_nxt.pc = jump_target(st_r.ir);            // RQ14
               st_nxt.flush = 1'b1;                         // RQ21
            end else if (take_irq) begin
               st_nxt.pc = rfp_pkg::IRQ_VEC;                // RQ22
               st_nxt.flush = 1'b1;
               st_nxt.irq_taken = 1'b1;
            end
         end
         default: begin
            st_nxt.ph = rfp_pkg::PH_ONE;
         end
      endcase
      // serial programming: lsb first, one word per 14 clocks
      st_nxt.rb6_prev = portb_bit6_prog_clock_i;
      if (!prog_mode_i) begin
         st_nxt.bit_cnt = 4'h0;
         st_nxt.prog_addr = 10'h000;
      end else if (portb_bit6_prog_clock_i && !st_r.rb6_prev) begin
         st_nxt.shift = {portb_bit7_prog_data_i, st_r.shift[13:1]}; // RQ20
         if (st_r.bit_cnt == rfp_pkg::PROG_LAST_BIT) begin
            st_nxt.bit_cnt = 4'h0;
            st_nxt.prog_we = 1'b1;
         end else begin
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
         end
      end
      if (st_r.prog_we) begin
         st_nxt.prog_addr = st_r.prog_addr + 10'h001;
      end
      // master clear or programming holds the core at its vector
      if (!resetn_i || prog_mode_i) begin                   // RQ16
         st_nxt.ph = rfp_pkg::PH_ONE;
         st_nxt.pc = rfp_pkg::RESET_VEC;                    // RQ22
         st_nxt.fetch_addr = rfp_pkg::RESET_VEC;
         st_nxt.fetch_word = rfp_pkg::INSTR_NOP;
         st_nxt.ir = rfp_pkg::INSTR_NOP;
         st_nxt.flush = 1'b1;
         st_nxt.alu = '0;
         st_nxt.ext_pend = 1'b0;
         st_nxt.chg_pend = 1'b0;
         st_nxt.irq_taken = 1'b0;
      end
      if (!resetn_i) begin
         st_nxt = '0;
         st_nxt.ph = rfp_pkg::PH_ONE;
         st_nxt.pc = rfp_pkg::RESET_VEC;
         st_nxt.flush = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // registers and memory writes
   // ------------------------------------------------------------------
   // state register
   always_ff @(posedge ref_clk_i) begin
      st_r <= st_nxt;
   end

   // memory writes: destination in phase four, programmer, data store
   always_ff @(posedge ref_clk_i) begin
      if (resetn_i && st_r.ph == rfp_pkg::PH_FOUR && st_r.alu.to_file &&
          in_gpr(st_r.ir[6:0])) begin
         gpr_mem[gpr_idx(st_r.ir[6:0])] <= st_r.alu.res;    // RQ13
      end
      if (st_r.prog_we) begin
         prog_mem[st_r.prog_addr] <= st_r.shift;            // RQ20
      end
      if (nv_we_i) begin
         nv_mem[nv_addr_i] <= nv_wdata_i;
      end
   end

   // outputs straight from the state register, port A bit 4 level tied low
   assign nv_rdata_o = st_r.nv_rdata;
   assign quarter_rate_clock_output_o = st_r.clk_out;
   assign porta4_out_o = 1'b0;                              // open drain
   assign porta4_oe_o = st_r.ra4_oe;
   assign timer_tick_o = st_r.timer_tick;
   assign irq_taken_o = st_r.irq_taken;
   assign instruction_pointer_o = st_r.pc;
   assign instr_reg_o = st_r.ir;
   assign accumulator_o = st_r.w;
   assign status_o = st_r.status;
   assign phase_o = st_r.ph;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i || prog_mode_i);

   sequence s_phases;
      st_r.ph == rfp_pkg::PH_TWO ##1 st_r.ph == rfp_pkg::PH_THREE ##1
      st_r.ph == rfp_pkg::PH_FOUR ##1 st_r.ph == rfp_pkg::PH_ONE;
   endsequence

   sequence s_quarter;
      !st_r.clk_out [*2] ##1 st_r.clk_out [*2];
   endsequence

   a_phase_cycle: assert property ( // RQ10
      st_r.ph == rfp_pkg::PH_ONE |=> s_phases)
      else $error("phases do not rotate in four");

   a_clk_quarter: assert property ( // RQ15
      (st_r.ph == rfp_pkg::PH_FOUR && rc_mode_i && $past(rc_mode_i))
      |=> s_quarter)
      else $error("clock output not at quarter rate");

   a_pc_step: assert property ( // RQ11
      st_r.ph == rfp_pkg::PH_ONE |=>
      (st_r.pc - $past(st_r.pc)) == 13'h0001 &&
      st_r.fetch_addr == $past(st_r.pc))
      else $error("pointer did not step in phase one");

   a_ir_load: assert property ( // RQ12
      (st_r.ph == rfp_pkg::PH_ONE && !st_r.flush) |=>
      st_r.ir == $past(st_r.fetch_word) [*4])
      else $error("instruction not held through cycle");

   property p_jump;
      logic [12:0] t;
      (st_r.ph == rfp_pkg::PH_FOUR && is_jump(st_r.ir),
       t = jump_target(st_r.ir))
      |=> st_r.pc == t ##1 (st_r.ir == rfp_pkg::INSTR_NOP &&
                            st_r.fetch_addr == t);
   endproperty

   a_jump_flush: assert property (p_jump) // RQ14 RQ21
      else $error("jump did not flush and refetch");

   a_reset_vec: assert property ( // RQ22
      $rose(resetn_i) |-> st_r.pc == rfp_pkg::RESET_VEC &&
                          st_r.ph == rfp_pkg::PH_ONE)
      else $error("reset vector not taken");

   a_irq_vec: assert property ( // RQ22
      (st_r.ph == rfp_pkg::PH_FOUR && take_irq) |=>
      st_r.pc == rfp_pkg::IRQ_VEC && st_r.irq_taken ##1 !st_r.irq_taken)
      else $error("interrupt vector not taken");

   property p_movlw;
      logic [7:0] k;
      (st_r.ph == rfp_pkg::PH_ONE && !st_r.flush &&
       st_r.fetch_word[13:8] == {2'h0, rfp_pkg::OP_MOVLW},
       k = st_r.fetch_word[7:0])
      |=> ##3 st_r.w == k;
   endproperty

   a_movlw_w: assert property (p_movlw) // RQ2 RQ6
      else $error("literal not in accumulator at cycle end");

   a_sub_borrow: assert property ( // RQ9
      (st_r.ph == rfp_pkg::PH_FOUR &&
       st_r.ir[13:8] == {2'h0, rfp_pkg::OP_SUBTRACT_ACCUMULATOR_FROM_FILE} &&
       st_r.ir[6:0] != rfp_pkg::STATUS_ADDR)
      |=> st_r.status[rfp_pkg::C_BIT] ==
          ($past(st_r.operand) >= $past(st_r.w)))
      else $error("subtract carry is not inverted borrow");

endmodule : rfp_core

// File: src/rfp_pkg.sv
/*
 * rfp_pkg: constants and carrier types for the fetch/execute core.
 * Assumes a single 100 MHz reference clock and synchronous pin inputs.
 */
package rfp_pkg;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int PHASES_PER_CYCLE = 4;
   localparam int INSTR_CYCLE_NS = CLK_PERIOD_NS * PHASES_PER_CYCLE;

   // ------------------------------------------------------------------
   // memory geometry and vectors
   // ------------------------------------------------------------------
   localparam int INSTR_W = 14;
   localparam int PC_W = 13;
   localparam int PROG_AW = 10;
   localparam int PROG_WORDS = 1024;
   localparam int GPR_COUNT = 36;
   localparam int NV_WORDS = 64;
   localparam int NV_AW = 6;
   localparam logic [6:0] GPR_BASE = 7'h0c;
   localparam logic [6:0] STATUS_ADDR = 7'h03;
   localparam logic [12:0] RESET_VEC = 13'h0000;
   localparam logic [12:0] IRQ_VEC = 13'h0004;
   localparam logic [3:0] PROG_LAST_BIT = 4'hd;

   // ------------------------------------------------------------------
   // status bit positions, instruction fields
   // ------------------------------------------------------------------
   localparam int C_BIT = 0;
   localparam int DC_BIT = 1;
   localparam int Z_BIT = 2;
   localparam logic [13:0] INSTR_NOP = 14'h0000;
   localparam int JUMP_BIT = 13;

   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_MOVWF = 4'h1;
   localparam logic [3:0] OP_MOVF = 4'h2;
   localparam logic [3:0] OP_ADDWF = 4'h3;
   localparam logic [3:0] OP_SUBTRACT_ACCUMULATOR_FROM_FILE = 4'h4;
   localparam logic [3:0] OP_ANDWF = 4'h5;
   localparam logic [3:0] OP_IORWF = 4'h6;
   localparam logic [3:0] OP_XORWF = 4'h7;
   localparam logic [3:0] OP_RRF = 4'h8;
   localparam logic [3:0] OP_RLF = 4'h9;
   localparam logic [3:0] OP_MOVLW = 4'ha;
   localparam logic [3:0] OP_ADDLW = 4'hb;
   localparam logic [3:0] OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL = 4'hc;
   localparam logic [3:0] OP_ANDLW = 4'hd;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} rfp_phase_e;

   typedef struct packed {
      logic [7:0] res;
      logic [2:0] flags;   // {z, dc, c}
      logic [2:0] upd;     // which flags change
      logic to_file;
      logic to_w;
   } rfp_alu_s;

   typedef struct packed {
      rfp_phase_e ph;
      logic [12:0] pc;
      logic [12:0] fetch_addr;
      logic [13:0] fetch_word;
      logic [13:0] ir;
      logic flush;
      logic [7:0] w;
      logic [2:0] status;
      logic [7:0] operand;
      rfp_alu_s alu;
      logic ext_pend;
      logic chg_pend;
      logic irq_taken;
      logic rb0_prev;
      logic [3:0] rb_hi_prev;
      logic ra4_prev;
      logic timer_tick;
      logic ra4_oe;
      logic clk_out;
      logic rb6_prev;
      logic [13:0] shift;
      logic [3:0] bit_cnt;
      logic [9:0] prog_addr;
      logic prog_we;
      logic [7:0] nv_rdata;
   } rfp_state_s;

endpackage : rfp_pkg
